// *** hdl/dlf_regs.vh ***
// constants for the discrete logic function library
`ifndef DLF_REGS_VH
`define DLF_REGS_VH
`define DLF_TMR_W        16
`define DLF_TMR_DLY_DEF  16'h0010
`define DLF_AB_W         16
`define DLF_AB_LIM_DEF   16'h0100
`define DLF_ST_IDLE      2'h0
`define DLF_ST_MOVE      2'h1
`define DLF_ST_DONE      2'h2
`define DLF_ST_FAULT     2'h3
`endif

// *** hdl/dlf_timer.v ***
// one tick-counting timer: on-delay, off-delay or one-shot
`timescale 1ns/10ps
`include "dlf_regs.vh"
module dlf_timer #(
    parameter       MODE = 0,           // 0 on-delay, 1 off-delay, 2 one-shot
    parameter       W    = `DLF_TMR_W
) (
    // clock and reset
    input  wire         clock,
    input  wire         rst_n,
    // timing
    input  wire [W-1:0] span,
    input  wire         in_sig,
    output reg          out_q
);
    reg [W-1:0] cnt_q;
    reg         prev_q;
    wire        rise = in_sig & ~prev_q;
    wire        done = (cnt_q + 1'b1 >= span);

    // counting starts afresh at every input change (only at a rise in the one-shot), so a reversal restarts it
    always @(posedge clock) begin
        if (!rst_n) begin
            cnt_q  <= {W{1'b0}};
            prev_q <= 1'b0;
            out_q  <= 1'b0;
        end else begin
            prev_q <= in_sig;
            // a one-shot restarts only on a rise, so a fall cannot stretch its pulse
            if ((MODE == 2) ? rise : (in_sig != prev_q)) begin
                cnt_q <= {W{1'b0}};
            end else if (cnt_q != {W{1'b1}}) begin
                cnt_q <= cnt_q + 1'b1;
            end
            case (MODE)
                0: begin
                    if (!in_sig)
                        out_q <= 1'b0;
                    else if (in_sig == prev_q && done)
                        out_q <= 1'b1;
                end
                1: begin
                    if (in_sig)
                        out_q <= 1'b1;
                    else if (in_sig == prev_q && done)
                        out_q <= 1'b0;
                end
                default: begin
                    // pulse length fixed by span, input fall does not cut it short
                    if (rise && span != {W{1'b0}})
                        out_q <= 1'b1;
                    else if (out_q && done && !rise)
                        out_q <= 1'b0;
                end
            endcase
        end
    end
endmodule

// *** hdl/dlf_top.v ***
// discrete logic function library: gates, voters, latches, timers, answer-back
`timescale 1ns/10ps
`include "dlf_regs.vh"
module dlf_top #(
    parameter TW = `DLF_TMR_W,
    parameter AW = `DLF_AB_W
) (
    // clock and reset
    input  wire          clock,
    input  wire          rst_n,
    // gate inputs, lowest bits used by narrower gates
    input  wire [29:0]   and_in,
    input  wire [29:0]   or_in,
    input  wire          not_in,
    // voter inputs
    input  wire [2:0]    vote3_in,
    input  wire [3:0]    vote4_in,
    // latch inputs
    input  wire          sr_set,
    input  wire          sr_clr,
    input  wire          tgl_in,
    input  wire          tgr_in,
    input  wire          tgr_clr,
    // timer inputs
    input  wire          ond_in,
    input  wire          ofd_in,
    input  wire          osh_in,
    input  wire [TW-1:0] ond_span,
    input  wire [TW-1:0] ofd_span,
    input  wire [TW-1:0] osh_span,
    // answer-back: 0 aux unit, 1 power valve, 2 pneumatic valve
    input  wire [2:0]    ab_cmd,
    input  wire [2:0]    ab_fb,
    input  wire [AW-1:0] ab_limit,
    // gate outputs
    output reg  [6:0]    and_out,
    output reg  [6:0]    or_out,
    output reg           not_out,
    // voter outputs
    output reg           v23_out,
    output reg           v24_out,
    output reg           v34_out,
    // latch outputs
    output reg           sr_q,
    output reg           tgl_q,
    output reg           tgr_q,
    // timer outputs
    output wire          ond_out,
    output wire          ofd_out,
    output wire          osh_out,
    // answer-back outputs
    output reg  [2:0]    ab_err,
    output reg  [3*AW-1:0] ab_time
);
    // synchronised copies of all inputs except the spans and ab_limit (application logic may be async)
    localparam NIN = 30 + 30 + 1 + 3 + 4 + 5 + 3 + 3 + 3;
    wire [NIN-1:0] raw = {and_in, or_in, not_in, vote3_in, vote4_in, sr_set, sr_clr,
                          tgl_in, tgr_in, tgr_clr, ond_in, ofd_in, osh_in, ab_cmd, ab_fb};
    reg  [NIN-1:0] s1_q;
    reg  [NIN-1:0] s2_q;

    // two-stage synchroniser, only the second stage feeds logic
    always @(posedge clock) begin
        if (!rst_n) begin
            s1_q <= {NIN{1'b0}};
            s2_q <= {NIN{1'b0}};
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    wire [29:0] a_s   = s2_q[81:52];
    wire [29:0] o_s   = s2_q[51:22];
    wire        n_s   = s2_q[21];
    wire [2:0]  v3_s  = s2_q[20:18];
    wire [3:0]  v4_s  = s2_q[17:14];
    wire        set_s = s2_q[13];
    wire        clr_s = s2_q[12];
    wire        tg_s  = s2_q[11];
    wire        tr_s  = s2_q[10];
    wire        trc_s = s2_q[9];
    wire        ond_s = s2_q[8];
    wire        ofd_s = s2_q[7];
    wire        osh_s = s2_q[6];
    wire [2:0]  cmd_s = s2_q[5:3];
    wire [2:0]  fb_s  = s2_q[2:0];

    // vote counts
    wire [1:0] n3 = {1'b0, v3_s[0]} + {1'b0, v3_s[1]} + {1'b0, v3_s[2]};
    wire [2:0] n4 = {2'b0, v4_s[0]} + {2'b0, v4_s[1]} + {2'b0, v4_s[2]}
                  + {2'b0, v4_s[3]};

    // combinational gates and voters, registered so outputs come from flops
    always @(posedge clock) begin
        if (!rst_n) begin
            and_out <= 7'h00;
            or_out  <= 7'h00;
            not_out <= 1'b0;
            v23_out <= 1'b0;
            v24_out <= 1'b0;
            v34_out <= 1'b0;
        end else begin
            and_out <= {&a_s[29:0], &a_s[19:0], &a_s[9:0], &a_s[4:0],
                        &a_s[3:0], &a_s[2:0], &a_s[1:0]};
            or_out  <= {|o_s[29:0], |o_s[19:0], |o_s[9:0], |o_s[4:0],
                        |o_s[3:0], |o_s[2:0], |o_s[1:0]};
            not_out <= ~n_s;
            v23_out <= (n3 >= 2'h2);
            v24_out <= (n4 >= 3'h2);
            v34_out <= (n4 >= 3'h3);
        end
    end

    // latches; previous levels kept for edge detection
    reg tg_prev_q;
    reg tr_prev_q;
    always @(posedge clock) begin
        if (!rst_n) begin
            sr_q      <= 1'b0;
            tgl_q     <= 1'b0;
            tgr_q     <= 1'b0;
            tg_prev_q <= 1'b0;
            tr_prev_q <= 1'b0;
        end else begin
            tg_prev_q <= tg_s;
            tr_prev_q <= tr_s;
            // reset has priority so a stuck set can still be cleared
            if (clr_s)
                sr_q <= 1'b0;
            else if (set_s)
                sr_q <= 1'b1;
            if (tg_s && !tg_prev_q)
                tgl_q <= ~tgl_q;
            if (trc_s)
                tgr_q <= 1'b0;
            else if (tr_s && !tr_prev_q)
                tgr_q <= ~tgr_q;
        end
    end

    // timers
    dlf_timer #(.MODE(0), .W(TW)) u_ond (
        .clock  (clock),
        .rst_n  (rst_n),
        .span   (ond_span),
        .in_sig (ond_s),
        .out_q  (ond_out)
    );
    dlf_timer #(.MODE(1), .W(TW)) u_ofd (
        .clock  (clock),
        .rst_n  (rst_n),
        .span   (ofd_span),
        .in_sig (ofd_s),
        .out_q  (ofd_out)
    );
    dlf_timer #(.MODE(2), .W(TW)) u_osh (
        .clock  (clock),
        .rst_n  (rst_n),
        .span   (osh_span),
        .in_sig (osh_s),
        .out_q  (osh_out)
    );

    // answer-back: each channel times feedback against command; mismatch past
    // limit is an error that stays until command and feedback agree again
    reg [1:0]    st_q [0:2];
    reg [AW-1:0] tm_q [0:2];
    integer i;
    always @(posedge clock) begin
        if (!rst_n) begin
            for (i = 0; i < 3; i = i + 1) begin
                st_q[i] <= `DLF_ST_IDLE;
                tm_q[i] <= {AW{1'b0}};
            end
            ab_err  <= 3'h0;
            ab_time <= {3*AW{1'b0}};
        end else begin
            for (i = 0; i < 3; i = i + 1) begin
                case (st_q[i])
                    `DLF_ST_IDLE, `DLF_ST_DONE: begin
                        if (cmd_s[i] != fb_s[i]) begin
                            st_q[i] <= `DLF_ST_MOVE;
                            tm_q[i] <= {AW{1'b0}};
                        end
                    end
                    `DLF_ST_MOVE: begin
                        if (cmd_s[i] == fb_s[i]) begin
                            st_q[i] <= `DLF_ST_DONE;
                            ab_time[i*AW +: AW] <= tm_q[i];
                            ab_err[i] <= 1'b0;
                        end else if (tm_q[i] >= ab_limit) begin
                            st_q[i]   <= `DLF_ST_FAULT;
                            ab_err[i] <= 1'b1;
                        end else begin
                            tm_q[i] <= tm_q[i] + 1'b1;
                        end
                    end
                    default: begin
                        if (cmd_s[i] == fb_s[i]) begin
                            st_q[i]   <= `DLF_ST_DONE;
                            ab_err[i] <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end
endmodule

// *** dv/dlf_top_chk.sv ***
// checker bound to the logic library top
`timescale 1ns/10ps
module dlf_chk (
    // clock and reset
    input wire        clock,
    input wire        rst_n,
    // watched inputs
    input wire [29:0] and_in,
    input wire [29:0] or_in,
    input wire        not_in,
    input wire        sr_set,
    input wire        sr_clr,
    input wire        tgl_in,
    input wire        tgr_clr,
    input wire        osh_in,
    // watched outputs
    input wire [6:0]  and_out,
    input wire [6:0]  or_out,
    input wire        not_out,
    input wire        sr_q,
    input wire        tgl_q,
    input wire        tgr_q,
    input wire        osh_out
);
    reg [2:0] up_q;
    // sync pipe holds reset values for a few edges, so checks wait it out
    always @(posedge clock) begin
        up_q <= rst_n ? up_q + {2'h0, up_q != 3'h7} : 3'h0;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n || up_q != 3'h7);
    and_gate_a:
        assert property (and_out[6] == $past(&and_in, 3) && and_out[0] == $past(&and_in[1:0], 3))
        else $error("and gate output wrong");
    or_gate_a:
        assert property (or_out[6] == $past(|or_in, 3) && or_out[3] == $past(|or_in[4:0], 3))
        else $error("or gate output wrong");
    inverter_a:
        assert property (not_out != $past(not_in, 3)) else $error("inverter output wrong");
    sr_clear_a:
        assert property ($past(sr_clr, 3) |-> !sr_q) else $error("latch not cleared");
    sr_set_a:
        assert property ($past(sr_set && !sr_clr, 3) |-> sr_q) else $error("latch not set");
    toggle_flip_a:
        assert property (tgl_q == ($past(tgl_q) ^ ($past(tgl_in, 3) && !$past(tgl_in, 4))))
        else $error("toggle output wrong");
    toggle_clear_a:
        assert property ($past(tgr_clr, 3) |-> !tgr_q) else $error("toggle not cleared");
    one_shot_a:
        assert property ($rose(osh_out) |-> $past(osh_in, 3) && !$past(osh_in, 4))
        else $error("one-shot started without input rise");
    cover property ($rose(sr_q));
    cover property ($fell(tgr_q));
    cover property ($fell(osh_out));
endmodule
bind dlf_top dlf_chk u_chk (
    .clock, .rst_n, .and_in, .or_in, .not_in, .sr_set, .sr_clr, .tgl_in,
    .tgr_clr, .osh_in, .and_out, .or_out, .not_out, .sr_q, .tgl_q, .tgr_q, .osh_out
);

// *** dv/dlf_plant.sv ***
// plant model: feedback follows the command after a lag, or sticks
`timescale 1ns/10ps
module dlf_plant (
    // clock and behaviour
    input wire       clock,
    input wire       stuck,
    input wire [3:0] lag,
    // command and answer-back
    input wire [2:0] ab_cmd,
    output reg [2:0] ab_fb
);
    reg [3:0] lag_q = 4'h0;
    initial ab_fb = 3'h0;
    // a stuck unit never answers, so the judgment must time out
    always @(posedge clock) begin
        lag_q <= (ab_cmd == ab_fb || stuck) ? 4'h0 : lag_q + 4'h1;
        if (!stuck && lag_q >= lag) begin
            ab_fb <= ab_cmd;
        end
    end
endmodule

// *** dv/dlf_top_tb.sv ***
// self-checking bench for the logic library top
`timescale 1ns/10ps
module dlf_top_tb;
    reg         clock, rst_n, not_in, sr_set, sr_clr, tgl_in, tgr_in, tgr_clr;
    reg         ond_in, ofd_in, osh_in, stuck;
    reg  [29:0] and_in, or_in;
    reg  [2:0]  vote3_in, ab_cmd;
    reg  [3:0]  vote4_in, lag;
    reg  [15:0] span, ab_limit;
    reg  [31:0] r;
    wire [6:0]  and_out, or_out;
    wire [2:0]  ab_fb, ab_err, tmr_o;
    wire [47:0] ab_time;
    wire        not_out, v23_out, v24_out, v34_out, sr_q, tgl_q, tgr_q;
    integer     fail_count, tests_run, k, n, m, ms, mt, mr, prev;
    dlf_top dut (
        .clock, .rst_n, .and_in, .or_in, .not_in, .vote3_in, .vote4_in, .sr_set, .sr_clr,
        .tgl_in, .tgr_in, .tgr_clr, .ond_in, .ofd_in, .osh_in, .ond_span(span),
        .ofd_span(span), .osh_span(span), .ab_cmd, .ab_fb, .ab_limit, .and_out, .or_out,
        .not_out, .v23_out, .v24_out, .v34_out, .sr_q, .tgl_q, .tgr_q, .ond_out(tmr_o[0]),
        .ofd_out(tmr_o[1]), .osh_out(tmr_o[2]), .ab_err, .ab_time
    );
    dlf_plant plant (.clock, .stuck, .lag, .ab_cmd, .ab_fb);
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // bounded wait on one timer output, counting falling edges
    task waitv(input integer s, input logic v, output integer c);
        c = 0;
        while (tmr_o[s] !== v && c < 90) begin
            @(negedge clock);
            c = c + 1;
        end
        if (c == 90) begin
            fail_count = fail_count + 1;
            end_sim;
        end
    endtask
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // main sequence; gate and latch inputs are held four cycles so outputs have settled
    initial begin
        {rst_n, not_in, sr_set, sr_clr, tgl_in, tgr_in, tgr_clr, ond_in, ofd_in, osh_in} = 0;
        {and_in, or_in, vote3_in, vote4_in, ab_cmd, fail_count, tests_run, ms, mt, mr, prev} = 0;
        {stuck, lag, span, ab_limit, r} = {1'b0, 4'h3, 16'h0006, 16'h0014, 32'h0000005E};
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        // one zero or one one at a random place hits every gate width edge
        for (k = 0; k < 48; k = k + 1) begin
            r = lfsr(lfsr(r));
            @(posedge clock);
            and_in <= ~(30'h1 << r[4:0]);
            or_in <= 30'h1 << r[9:5];
            {not_in, vote4_in, vote3_in} <= r[17:10];
            repeat (4) @(negedge clock);
            for (n = 0; n < 7; n = n + 1) begin
                m = (1 << (n < 4 ? n + 2 : (n - 3) * 10)) - 1;
                check("and_out", and_out[n], (and_in & m) == m);
                check("or_out", or_out[n], (or_in & m) != 0);
            end
            check("not_out", not_out, !not_in);
            check("v23_out", v23_out, $countones(vote3_in) >= 2);
            check("v24_out", v24_out, $countones(vote4_in) >= 2);
            check("v34_out", v34_out, $countones(vote4_in) >= 3);
        end
        // set, idle, clear, both, set, idle
        for (k = 0; k < 6; k = k + 1) begin
            @(posedge clock);
            {sr_clr, sr_set} <= 2'(12'h1E1 >> (2 * k));
            repeat (4) @(negedge clock);
            ms = sr_clr ? 0 : (sr_set ? 1 : ms);
            check("sr_q", sr_q, ms);
        end
        // random toggle input with the clear held for a stretch
        for (k = 0; k < 16; k = k + 1) begin
            r = lfsr(r);
            @(posedge clock);
            {tgl_in, tgr_in, tgr_clr} <= {r[0], r[0], k > 8 && k < 12};
            repeat (4) @(negedge clock);
            mt = mt ^ (tgl_in && !prev);
            mr = tgr_clr ? 0 : mr ^ (tgr_in && !prev);
            prev = tgl_in;
            check("tgl_q", tgl_q, mt);
            check("tgr_q", tgr_q, mr);
        end
        @(posedge clock);
        {ond_in, ofd_in} <= 2'h3;
        waitv(0, 1'b1, n);
        check("ond_time", n > span && n <= span + 4, 1);
        @(posedge clock);
        {ond_in, ofd_in} <= 2'h0;
        waitv(1, 1'b0, n);
        check("ofd_time", n > span && n <= span + 4, 1);
        // a short high then a low must restart the on-delay count
        @(posedge clock);
        ond_in <= 1'b1;
        repeat (3) @(posedge clock);
        ond_in <= 1'b0;
        repeat (2) @(posedge clock);
        ond_in <= 1'b1;
        waitv(0, 1'b1, n);
        check("ond_retry", n > span && n <= span + 4, 1);
        @(posedge clock);
        osh_in <= 1'b1;
        waitv(2, 1'b1, n);
        waitv(2, 1'b0, n);
        check("osh_width", n, span);
        @(posedge clock);
        ab_cmd <= 3'h7;
        repeat (30) @(negedge clock);
        check("ab_err", ab_err, 3'h0);
        check("ab_time", ab_time[15:0] >= lag && ab_time[15:0] <= lag + 6, 1);
        check("ab_time1", ab_time[31:16] >= lag && ab_time[31:16] <= lag + 6, 1);
        check("ab_time2", ab_time[47:32] >= lag && ab_time[47:32] <= lag + 6, 1);
        @(posedge clock);
        {stuck, ab_cmd} <= 4'h8;
        for (n = 0; n < 90 && ab_err !== 3'h7; n = n + 1) @(negedge clock);
        check("ab_late", n >= ab_limit && n <= ab_limit + 6, 1);
        if (n == 90) begin
            end_sim;
        end
        @(posedge clock);
        stuck <= 1'b0;
        repeat (20) @(negedge clock);
        check("ab_err", ab_err, 3'h0);
        end_sim;
    end
endmodule
